//--- logic/hdc_pkg.sv
// Package of offsets, field positions, reset values and timing counts for the haptic config bank.
package hdc_pkg;

  // ====================
  // Register offsets on the host register port.
  localparam logic [7:0] RATED_DRIVE_VOLTAGE_ADDR = 8'h16; // Full-scale drive code.
  localparam logic [7:0] OVERDRIVE_CLAMP_ADDR     = 8'h17; // Drive reference for open loop.
  localparam logic [7:0] CAL_COMP_ADDR            = 8'h18; // Calibration compensation.
  localparam logic [7:0] CAL_BACKEMF_ADDR         = 8'h19; // Calibrated back-EMF result.
  localparam logic [7:0] FEEDBACK_CTRL_ADDR       = 8'h1a; // Feedback control, last copied.
  localparam logic [7:0] DRIVE_OPTIONS_ADDR       = 8'h1d; // Drive-option control bits.
  localparam logic [7:0] CAL_MEM_IF_ADDR          = 8'h1e; // Calibration memory interface.
  localparam logic [7:0] SUPPLY_MONITOR_ADDR      = 8'h21; // Supply voltage monitor.
  localparam logic [7:0] RESONANCE_PERIOD_ADDR    = 8'h22; // Resonance period readback.

  // ====================
  // Field positions.
  localparam int OPT_FIXED_FREQ_BIT  = 0; // Divide-by-128 commutation select.
  localparam int OPT_INPUT_KIND_BIT  = 1; // Input kind: 0 pulse width, 1 analog.
  localparam int OPT_UPDATE_RATE_BIT = 2; // Amplitude update rate select.
  localparam int OPT_SAMPLE_FMT_BIT  = 3; // Live sample format select.
  localparam int OPT_SUPPLY_OFF_BIT  = 4; // Supply compensation off.
  localparam int CAL_PROGRAM_BIT     = 0; // Launch of non-volatile programming.
  localparam int CAL_STATUS_BIT      = 2; // Programmed status, read only.
  localparam int CAL_TIME_LSB        = 4; // Calibration duration select, low bit.

  // ====================
  // Reset values.
  localparam logic [7:0] DRIVE_OPTIONS_RST = 8'h00; // All options off.
  localparam logic [1:0] CAL_TIME_RST      = 2'h2;  // 500 ms to 700 ms.
  localparam logic [7:0] DATA_RST          = 8'h00; // Plain data registers.

  // ====================
  // Timing.
  localparam int CLK_HZ         = 20_000_000; // Reference clock rate.
  localparam int CAL_MIN_MS_0   = 150;        // Duration code 0, least time.
  localparam int CAL_MIN_MS_1   = 250;        // Duration code 1, least time.
  localparam int CAL_MIN_MS_2   = 500;        // Duration code 2, least time.
  localparam int CAL_MIN_MS_3   = 1000;       // Duration code 3, least time.
  localparam int MS_CYCLES      = CLK_HZ / 1000; // Cycles in one millisecond.
  localparam int FIXED_FREQ_DIV = 128;        // Pulse-width edges per commutation.
  localparam int NVM_WORDS      = 5;          // Registers copied into non-volatile memory.
  localparam int NVM_WRITE_CYC  = 16;         // Cycles per copied word, unused; each word waits for nvm_ack_i.

endpackage

//--- logic/hdc_ms_timer.sv
// Millisecond-scale down counter that times the calibration duration.
`timescale 1ns/100ps
module hdc_ms_timer (
  input  wire logic        ref_clk_i, // Clock.
  input  wire logic        rst_i,     // Synchronous reset, active high.
  input  wire logic        start_i,   // Load the count and start.
  input  wire logic [10:0] ms_i,      // Length in milliseconds.
  output logic             busy_o,    // High while counting.
  output logic             done_o     // One-cycle pulse at the end.
);

  logic [14:0] tick_q; // Cycles inside the current millisecond.
  logic [10:0] ms_q;   // Milliseconds still to run.

  // ====================
  // Count down whole milliseconds; a restart simply reloads.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tick_q <= 15'h0000;
      ms_q   <= 11'h000;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        tick_q <= 15'h0000;
        ms_q   <= ms_i;
        busy_o <= 1'b1;
      end else if (busy_o) begin
        if (tick_q == 15'(hdc_pkg::MS_CYCLES - 1)) begin
          tick_q <= 15'h0000;
          if (ms_q <= 11'h001) begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
          end
          ms_q <= ms_q - 11'h001;
        end else begin
          tick_q <= tick_q + 15'h0001;
        end
      end
    end
  end

endmodule

//--- logic/hdc_edge_div.sv
// Divider that gives one pulse for every DIV rising edges of a sampled input.
`timescale 1ns/100ps
module hdc_edge_div #(
  parameter int DIV = 128 // Edges per output pulse.
) (
  input  wire logic ref_clk_i, // Clock.
  input  wire logic rst_i,     // Synchronous reset, active high.
  input  wire logic enable_i,  // Counting allowed.
  input  wire logic sig_i,     // Sampled input signal.
  output logic      pulse_o    // One-cycle pulse every DIV edges.
);

  logic       sig_q; // Previous sample for edge detection.
  logic [7:0] cnt_q; // Edges seen so far.

  // ====================
  // Count rising edges; the count restarts whenever the divider is off.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sig_q   <= 1'b0;
      cnt_q   <= 8'h00;
      pulse_o <= 1'b0;
    end else begin
      sig_q   <= sig_i;
      pulse_o <= 1'b0;
      if (!enable_i) begin
        cnt_q <= 8'h00;
      end else if (sig_i && !sig_q) begin
        if (cnt_q == 8'(DIV - 1)) begin
          cnt_q   <= 8'h00;
          pulse_o <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 8'h01;
        end
      end
    end
  end

endmodule

//--- logic/hdc_config_regs.sv
// Configuration and status register bank of the haptic actuator driver.
// Function
// - Update bit picks one or two updates
// - Fixed-frequency option divides pulse input by 128
// - Duration field selects calibration time
// - Launch copies 0x16 to 0x1A into memory
// - Programming runs only once ever
// - Status bit 2 shows memory programmed
// - Supply monitor follows its sample only while driving
// - Period readback follows its sample only while driving
// - Rated code sets closed-loop full scale
// - Open loop uses overdrive clamp instead
// - Calibration reads the rated code
// - Eccentric closed loop scales by 5.44/255
// - Resonant closed loop scales by 5.28/255
// - Compensation-off bit stops supply adjustment
// - Fixed-frequency option defaults to auto resonance
`timescale 1ns/100ps
module hdc_config_regs (
  input  wire logic       ref_clk_i,          // 20 MHz clock.
  input  wire logic       rst_i,              // Synchronous reset, active high.
  input  wire logic       reg_wr_i,           // Register write strobe.
  input  wire logic       reg_rd_i,           // Register read strobe.
  input  wire logic [7:0] reg_addr_i,         // Register offset.
  input  wire logic [7:0] reg_wdata_i,        // Write data.
  output logic      [7:0] reg_rdata_o,        // Read data, registered.
  input  wire logic       nvm_blank_i,        // Non-volatile memory still blank at power up.
  input  wire logic       nvm_ack_i,          // Memory accepted the current word.
  output logic            nvm_wr_o,           // Memory write request, level.
  output logic      [2:0] nvm_idx_o,          // Word index being written.
  output logic      [7:0] nvm_data_o,         // Word being written.
  input  wire logic       cal_start_i,        // Calibration start from the engine.
  output logic            cal_busy_o,         // Calibration duration running.
  output logic            cal_done_o,         // One-cycle pulse at end of calibration.
  output logic      [7:0] cal_rated_code_o,   // Rated code handed to calibration.
  input  wire logic       driving_i,          // A waveform is being driven.
  input  wire logic [7:0] supply_sample_i,    // Live supply sample.
  input  wire logic [7:0] period_sample_i,    // Live resonance period sample.
  input  wire logic       pwm_in_i,           // Sampled pulse-width input.
  input  wire logic       closed_loop_i,      // Engine runs a closed-loop mode.
  input  wire logic       resonant_i,         // Actuator is the resonant kind.
  output logic            commutate_o,        // Fixed-frequency commutation pulse.
  output logic            fixed_freq_o,       // Fixed-frequency mode in force.
  output logic            twice_per_cycle_o,  // Amplitude updated twice per cycle.
  output logic            unsigned_samples_o, // Live samples are unsigned.
  output logic            supply_comp_en_o,   // Supply compensation enabled.
  output logic      [7:0] full_scale_code_o,  // Drive reference code in force.
  output logic      [8:0] full_scale_mv_o     // Full scale in units of 20 mV steps.
);

  // ====================
  // Stored registers, plus the fixed_freq and cal_ms combinational decodes.
  logic [7:0] rated_code_q;  // Rated drive code.
  logic [7:0] od_clamp_q;    // Overdrive clamp code.
  logic [7:0] cal_comp_q;    // Calibration compensation.
  logic [7:0] cal_bemf_q;    // Calibrated back-EMF result.
  logic [7:0] fb_ctrl_q;     // Feedback control.
  logic [7:0] options_q;     // Drive-option bits.
  logic [1:0] cal_time_q;    // Calibration duration select.
  logic       nvm_done_q;    // Memory programmed.
  logic       launch_q;      // Launch bit as written, self clears.
  logic [7:0] supply_q;      // Supply monitor value.
  logic [7:0] period_q;      // Resonance period value.
  logic [2:0] nvm_idx_q;     // Word index of the copy.
  logic       strap_q;       // Blank state captured after reset.
  logic       fixed_freq;    // Fixed-frequency mode condition.
  logic [10:0] cal_ms;       // Calibration length in ms.

  typedef enum logic [1:0] {
    HDC_IDLE = 2'b00, // No copy running.
    HDC_COPY = 2'b01, // Writing words.
    HDC_DONE = 2'b10  // Copy finished for good.
  } hdc_nvm_state_t;
  hdc_nvm_state_t nvm_state_q; // Programming sequencer state.

  // ====================
  // Host writes to the plain configuration registers.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rated_code_q <= hdc_pkg::DATA_RST;
      od_clamp_q   <= hdc_pkg::DATA_RST;
      cal_comp_q   <= hdc_pkg::DATA_RST;
      cal_bemf_q   <= hdc_pkg::DATA_RST;
      fb_ctrl_q    <= hdc_pkg::DATA_RST;
      options_q    <= hdc_pkg::DRIVE_OPTIONS_RST;
      cal_time_q   <= hdc_pkg::CAL_TIME_RST;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        hdc_pkg::RATED_DRIVE_VOLTAGE_ADDR: rated_code_q <= reg_wdata_i;
        hdc_pkg::OVERDRIVE_CLAMP_ADDR:     od_clamp_q   <= reg_wdata_i;
        hdc_pkg::CAL_COMP_ADDR:            cal_comp_q   <= reg_wdata_i;
        hdc_pkg::CAL_BACKEMF_ADDR:         cal_bemf_q   <= reg_wdata_i;
        hdc_pkg::FEEDBACK_CTRL_ADDR:       fb_ctrl_q    <= reg_wdata_i;
        hdc_pkg::DRIVE_OPTIONS_ADDR:       options_q    <= reg_wdata_i;
        hdc_pkg::CAL_MEM_IF_ADDR: begin
          cal_time_q <= reg_wdata_i[hdc_pkg::CAL_TIME_LSB +: 2];
        end
        default: begin
          // Other offsets are not held here; 0x21 and 0x22 are written in the readback blocks below.
        end
      endcase
    end
  end

  // ====================
  // The blank level is caught one clock after reset, never under it.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      strap_q <= 1'b1;
    end else begin
      strap_q <= nvm_blank_i;
    end
  end

  // ====================
  // Launch bit reads back for one cycle, then clears by itself as the copy starts.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      launch_q <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == hdc_pkg::CAL_MEM_IF_ADDR &&
                 reg_wdata_i[hdc_pkg::CAL_PROGRAM_BIT]) begin
      launch_q <= 1'b1;
    end else if (nvm_state_q != HDC_COPY) begin
      launch_q <= 1'b0;
    end
  end

  // ====================
  // Copy sequencer. Once a memory is programmed it never starts again;
  // a part that powers up already programmed goes to the done state on the second clock after reset.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      nvm_state_q <= HDC_IDLE;
      nvm_idx_q   <= 3'h0;
      nvm_done_q  <= 1'b0;
    end else begin
      case (nvm_state_q)
        HDC_IDLE: begin
          if (!strap_q) begin
            nvm_state_q <= HDC_DONE;
            nvm_done_q  <= 1'b1;
          end else if (launch_q) begin
            nvm_state_q <= HDC_COPY;
            nvm_idx_q   <= 3'h0;
          end
        end
        HDC_COPY: begin
          if (nvm_ack_i) begin
            if (nvm_idx_q == 3'(hdc_pkg::NVM_WORDS - 1)) begin
              nvm_state_q <= HDC_DONE;
              nvm_done_q  <= 1'b1;
            end else begin
              nvm_idx_q <= nvm_idx_q + 3'h1;
            end
          end
        end
        HDC_DONE: begin
          nvm_state_q <= HDC_DONE;
        end
        default: nvm_state_q <= HDC_IDLE;
      endcase
    end
  end

  // ====================
  // Word presented to memory, registered so the data is stable under the request.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      nvm_data_o <= 8'h00;
      nvm_idx_o  <= 3'h0;
    end else begin
      nvm_idx_o <= nvm_idx_q;
      case (nvm_idx_q)
        3'h0:    nvm_data_o <= rated_code_q;
        3'h1:    nvm_data_o <= od_clamp_q;
        3'h2:    nvm_data_o <= cal_comp_q;
        3'h3:    nvm_data_o <= cal_bemf_q;
        default: nvm_data_o <= fb_ctrl_q;
      endcase
    end
  end
  assign nvm_wr_o = (nvm_state_q == HDC_COPY) && (nvm_idx_o == nvm_idx_q);

  // ====================
  // Live readbacks follow their samples only while a waveform is driven.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      supply_q <= hdc_pkg::DATA_RST;
    end else if (driving_i) begin
      supply_q <= supply_sample_i;
    end else if (reg_wr_i && reg_addr_i == hdc_pkg::SUPPLY_MONITOR_ADDR) begin
      supply_q <= reg_wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      period_q <= hdc_pkg::DATA_RST;
    end else if (driving_i) begin
      period_q <= period_sample_i;
    end else if (reg_wr_i && reg_addr_i == hdc_pkg::RESONANCE_PERIOD_ADDR) begin
      period_q <= reg_wdata_i;
    end
  end

  // ====================
  // Calibration duration: the least time of each code, since longer is safe.
  always_comb begin
    case (cal_time_q)
      2'h0:    cal_ms = 11'(hdc_pkg::CAL_MIN_MS_0);
      2'h1:    cal_ms = 11'(hdc_pkg::CAL_MIN_MS_1);
      2'h2:    cal_ms = 11'(hdc_pkg::CAL_MIN_MS_2);
      default: cal_ms = 11'(hdc_pkg::CAL_MIN_MS_3);
    endcase
  end

  hdc_ms_timer u_cal_timer (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .start_i   (cal_start_i),
    .ms_i      (cal_ms),
    .busy_o    (cal_busy_o),
    .done_o    (cal_done_o)
  );

  // Calibration takes the rated code as its input.
  assign cal_rated_code_o = rated_code_q;

  // ====================
  // Fixed-frequency commutation, only meaningful with pulse-width input.
  assign fixed_freq = options_q[hdc_pkg::OPT_FIXED_FREQ_BIT] &&
                      !options_q[hdc_pkg::OPT_INPUT_KIND_BIT];

  hdc_edge_div #(
    .DIV (hdc_pkg::FIXED_FREQ_DIV)
  ) u_commutate_div (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .enable_i  (fixed_freq),
    .sig_i     (pwm_in_i),
    .pulse_o   (commutate_o)
  );

  // ====================
  // Drive option outputs, registered.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      fixed_freq_o       <= 1'b0;
      twice_per_cycle_o  <= 1'b0;
      unsigned_samples_o <= 1'b0;
      supply_comp_en_o   <= 1'b1;
    end else begin
      fixed_freq_o       <= fixed_freq;
      twice_per_cycle_o  <= options_q[hdc_pkg::OPT_UPDATE_RATE_BIT];
      unsigned_samples_o <= options_q[hdc_pkg::OPT_SAMPLE_FMT_BIT];
      supply_comp_en_o   <= !options_q[hdc_pkg::OPT_SUPPLY_OFF_BIT];
    end
  end

  // ====================
  // Full-scale reference: rated code in closed loop, clamp code in open loop.
  // Scale in 20 mV steps: 5.44 V / 255 is 272/255 steps, 5.28 V is 264/255.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      full_scale_code_o <= 8'h00;
      full_scale_mv_o   <= 9'h000;
    end else if (closed_loop_i) begin
      full_scale_code_o <= rated_code_q;
      if (resonant_i) begin
        full_scale_mv_o <= 9'((17'(rated_code_q) * 17'd264) / 17'd255);
      end else begin
        full_scale_mv_o <= 9'((17'(rated_code_q) * 17'd272) / 17'd255);
      end
    end else begin
      full_scale_code_o <= od_clamp_q;
      full_scale_mv_o   <= 9'((17'(od_clamp_q) * 17'd272) / 17'd255);
    end
  end

  // ====================
  // Register reads, one cycle after the strobe; unmapped offsets read zero.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        hdc_pkg::RATED_DRIVE_VOLTAGE_ADDR: reg_rdata_o <= rated_code_q;
        hdc_pkg::OVERDRIVE_CLAMP_ADDR:     reg_rdata_o <= od_clamp_q;
        hdc_pkg::CAL_COMP_ADDR:            reg_rdata_o <= cal_comp_q;
        hdc_pkg::CAL_BACKEMF_ADDR:         reg_rdata_o <= cal_bemf_q;
        hdc_pkg::FEEDBACK_CTRL_ADDR:       reg_rdata_o <= fb_ctrl_q;
        hdc_pkg::DRIVE_OPTIONS_ADDR:       reg_rdata_o <= options_q;
        hdc_pkg::CAL_MEM_IF_ADDR: begin
          reg_rdata_o <= {2'b00, cal_time_q, 1'b0, nvm_done_q, 1'b0, launch_q};
        end
        hdc_pkg::SUPPLY_MONITOR_ADDR:      reg_rdata_o <= supply_q;
        hdc_pkg::RESONANCE_PERIOD_ADDR:    reg_rdata_o <= period_q;
        default:                           reg_rdata_o <= 8'h00;
      endcase
    end
  end

endmodule

//--- sim/hdc_nvm_model.sv
// Behavioural model of the non-volatile memory that takes the copied words.
`timescale 1ns/100ps
module hdc_nvm_model #(
  parameter int LAT = 3 // Cycles of delay before each word is accepted.
) (
  input  wire logic       ref_clk_i, // Clock.
  input  wire logic       wr_i,      // Write request level.
  input  wire logic [2:0] idx_i,     // Word index.
  input  wire logic [7:0] data_i,    // Word data.
  output logic            ack_o      // One-cycle accept pulse.
);
  logic [7:0] mem_q [0:7]; // Stored words, read by the bench.
  int         n_q = 0;     // Words stored over the whole run.
  int         cnt_q = 0;   // Wait counter, so a slow memory is seen too.
  initial ack_o = 1'b0;
  // ====================
  // Accept one word after LAT cycles of request; ack is dropped the next edge.
  always @(posedge ref_clk_i) begin
    ack_o <= 1'b0;
    if (wr_i && !ack_o) begin
      cnt_q <= cnt_q + 1;
      if (cnt_q == LAT) begin
        ack_o       <= 1'b1;
        mem_q[idx_i] <= data_i;
        n_q         <= n_q + 1;
        cnt_q       <= 0;
      end
    end
  end
endmodule

//--- sim/hdc_config_regs_checker.sv
// Concurrent checks on the ports of the haptic config bank.
`timescale 1ns/100ps
module hdc_config_regs_checker (
  input wire logic       ref_clk_i,         // Clock.
  input wire logic       rst_i,             // Reset.
  input wire logic       reg_wr_i,          // Write strobe.
  input wire logic [7:0] reg_addr_i,        // Offset.
  input wire logic [7:0] reg_wdata_i,       // Write data.
  input wire logic       cal_start_i,       // Calibration start.
  input wire logic       cal_busy_o,        // Calibration running.
  input wire logic       cal_done_o,        // Calibration end.
  input wire logic [7:0] cal_rated_code_o,  // Rated code to calibration.
  input wire logic       nvm_wr_o,          // Memory write request.
  input wire logic       nvm_ack_i,         // Memory accept.
  input wire logic [2:0] nvm_idx_o,         // Word index.
  input wire logic [7:0] nvm_data_o,        // Word data.
  input wire logic       commutate_o,       // Commutation pulse.
  input wire logic       fixed_freq_o,      // Fixed-frequency mode.
  input wire logic       twice_per_cycle_o, // Update rate.
  input wire logic       unsigned_samples_o,// Sample format.
  input wire logic       supply_comp_en_o   // Supply compensation.
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  wire opt_wr = reg_wr_i && reg_addr_i == hdc_pkg::DRIVE_OPTIONS_ADDR; // Option write.
  wire rtd_wr = reg_wr_i && reg_addr_i == hdc_pkg::RATED_DRIVE_VOLTAGE_ADDR; // Rated write.
  logic [2:0] acks_q; // Words accepted; saturates so a sixth copy is seen.
  // ====================
  // Count accepted words since the last reset.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) acks_q <= 3'h0;
    else if (nvm_wr_o && nvm_ack_i && acks_q != 3'h7) acks_q <= acks_q + 3'h1;
  end
  a_update_rate: assert property (opt_wr |-> ##2 twice_per_cycle_o == $past(reg_wdata_i[2], 2))
    else $error("update rate does not follow option write");
  a_sample_fmt: assert property (opt_wr |-> ##2 unsigned_samples_o == $past(reg_wdata_i[3], 2))
    else $error("sample format does not follow option write");
  a_supply_comp: assert property (opt_wr |-> ##2 supply_comp_en_o == !$past(reg_wdata_i[4], 2))
    else $error("supply compensation does not follow option write");
  a_fixed_mode: assert property (opt_wr |-> ##2
    fixed_freq_o == ($past(reg_wdata_i[0], 2) && !$past(reg_wdata_i[1], 2)))
    else $error("fixed frequency mode wrong after option write");
  a_commutate_mode: assert property (commutate_o |-> $past(fixed_freq_o))
    else $error("commutation pulse outside fixed frequency mode");
  a_rated_code: assert property (rtd_wr |-> ##2 cal_rated_code_o == $past(reg_wdata_i, 2))
    else $error("calibration does not see rated code");
  a_cal_busy: assert property (cal_start_i |=> cal_busy_o)
    else $error("calibration did not start");
  a_cal_hold: assert property ($rose(cal_busy_o) |-> ##1 (cal_busy_o && !cal_done_o)[*8])
    else $error("calibration ended far too early");
  a_nvm_hold: assert property (nvm_wr_o && !nvm_ack_i |=>
    nvm_wr_o && $stable(nvm_idx_o) && $stable(nvm_data_o))
    else $error("memory request dropped or changed before accept");
  a_nvm_once: assert property (nvm_wr_o |-> acks_q < 3'h5 && nvm_idx_o == acks_q)
    else $error("memory written beyond one programming pass");
  c_copy: cover property (nvm_wr_o && nvm_ack_i);
  c_comm: cover property (commutate_o);
  c_cal: cover property (cal_start_i);
endmodule
bind hdc_config_regs hdc_config_regs_checker hdc_config_regs_checker_i (.ref_clk_i, .rst_i,
  .reg_wr_i, .reg_addr_i, .reg_wdata_i, .cal_start_i, .cal_busy_o, .cal_done_o,
  .cal_rated_code_o, .nvm_wr_o, .nvm_ack_i, .nvm_idx_o, .nvm_data_o, .commutate_o,
  .fixed_freq_o, .twice_per_cycle_o, .unsigned_samples_o, .supply_comp_en_o);

//--- sim/tb_hdc_config_regs.sv
// Self-checking testbench of the haptic config bank.
`timescale 1ns/100ps
module tb_hdc_config_regs;
  logic ref_clk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, cal_start_i = 0;
  logic driving_i = 0, pwm_in_i = 0, closed_loop_i = 0, resonant_i = 0;
  logic nvm_blank_i = 1, nvm_ack_i, nvm_wr_o, cal_busy_o, commutate_o, fixed_freq_o;
  logic twice_per_cycle_o, unsigned_samples_o, supply_comp_en_o;
  logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, supply_sample_i = 0, period_sample_i = 0;
  logic [7:0] reg_rdata_o, nvm_data_o, full_scale_code_o, cal_rated_code_o, d;
  logic [2:0] nvm_idx_o;
  logic [8:0] full_scale_mv_o;
  int failures = 0, num_checks = 0, k;
  logic [7:0] vals [0:4] = '{8'hff, 8'h55, 8'h81, 8'h42, 8'hc3}; // Words 0x16..0x1a.
  always #25 ref_clk_i = ~ref_clk_i; // 20 MHz.
  hdc_config_regs hdc_config_regs_i (.ref_clk_i, .rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
    .reg_wdata_i, .reg_rdata_o, .nvm_blank_i, .nvm_ack_i, .nvm_wr_o, .nvm_idx_o, .nvm_data_o,
    .cal_start_i, .cal_busy_o, .cal_done_o(), .cal_rated_code_o, .driving_i, .supply_sample_i,
    .period_sample_i, .pwm_in_i, .closed_loop_i, .resonant_i, .commutate_o, .fixed_freq_o,
    .twice_per_cycle_o, .unsigned_samples_o, .supply_comp_en_o, .full_scale_code_o,
    .full_scale_mv_o);
  hdc_nvm_model hdc_nvm_model_i (.ref_clk_i(ref_clk_i), .wr_i(nvm_wr_o), .idx_i(nvm_idx_o),
    .data_i(nvm_data_o), .ack_o(nvm_ack_i));
  // ====================
  // Shared helpers: compare, cycle wait, and the register port.
  task chk(string n, logic [15:0] s, logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task cyc(int n); repeat (n) @(posedge ref_clk_i); endtask
  task wr(logic [7:0] a, logic [7:0] v);
    @(posedge ref_clk_i); reg_wr_i <= 1; reg_addr_i <= a; reg_wdata_i <= v;
    @(posedge ref_clk_i); reg_wr_i <= 0;
  endtask
  // Data is registered on the read edge, so it is taken just after it.
  task rd(logic [7:0] a);
    @(posedge ref_clk_i); reg_rd_i <= 1; reg_addr_i <= a;
    @(posedge ref_clk_i); reg_rd_i <= 0;
    #1 d = reg_rdata_o;
  endtask
  // ====================
  // Reset values, plus an unmapped read that must give zero.
  task t_reset;
    rd(8'h1e); chk("cal_if", d, 8'h20);
    rd(8'h1d); chk("options", d, 8'h00);
    rd(8'h21); chk("supply", d, 8'h00);
    rd(8'h22); chk("period", d, 8'h00);
    rd(8'h40); chk("unmapped", d, 8'h00);
    chk("comp_en", supply_comp_en_o, 1'b1);
    $display("test reset done");
  endtask
  // Each option bit alone, walked one at a time.
  task t_options;
    for (k = 0; k < 5; k++) begin
      wr(8'h1d, 8'h01 << k); cyc(3); rd(8'h1d);
      chk("opt_rb", d, 8'h01 << k);
      chk("fixed", fixed_freq_o, k == 0);
      chk("twice", twice_per_cycle_o, k == 2);
      chk("unsigned", unsigned_samples_o, k == 3);
      chk("comp_en", supply_comp_en_o, k != 4);
    end
    $display("test options done");
  endtask
  // 128 pulse-width periods give one commutation, none with analog input.
  task t_commutate;
    for (k = 0; k < 2; k++) begin
      wr(8'h1d, k ? 8'h03 : 8'h01); cyc(2); d = 0;
      repeat (260) begin
        @(posedge ref_clk_i); pwm_in_i <= ~pwm_in_i;
        #1 d += commutate_o;
      end
      chk("commutations", d, k ? 8'h00 : 8'h01);
    end
    wr(8'h1d, 8'h00);
    $display("test commutate done");
  endtask
  // Every duration code reads back; a start raises busy.
  task t_caltime;
    for (k = 0; k < 4; k++) begin
      wr(8'h1e, k << 4); rd(8'h1e); chk("cal_time", d, k << 4);
    end
    wr(8'h16, 8'h80);
    @(posedge ref_clk_i); cal_start_i <= 1;
    @(posedge ref_clk_i); cal_start_i <= 0;
    #1 chk("cal_busy", cal_busy_o, 1'b1);
    chk("cal_code", cal_rated_code_o, 8'h80);
    cyc(20); chk("cal_busy", cal_busy_o, 1'b1);
    $display("test caltime done");
  endtask
  // Readbacks follow samples only while a waveform is driven.
  task t_readback;
    driving_i <= 1; supply_sample_i <= 8'ha5; period_sample_i <= 8'h3c; cyc(3);
    rd(8'h21); chk("supply", d, 8'ha5);
    rd(8'h22); chk("period", d, 8'h3c);
    cyc(1);
    driving_i <= 0; supply_sample_i <= 8'h5a; period_sample_i <= 8'hc3; cyc(3);
    rd(8'h21); chk("supply", d, 8'ha5);
    rd(8'h22); chk("period", d, 8'h3c);
    wr(8'h21, 8'h7e); rd(8'h21); chk("supply_wr", d, 8'h7e);
    $display("test readback done");
  endtask
  // One programming pass copies five words; a second launch does nothing.
  task t_nvm;
    for (k = 0; k < 5; k++) wr(8'h16 + k, vals[k]);
    wr(8'h1e, 8'h21); d = 0;
    for (k = 0; k < 60 && d[2] !== 1'b1; k++) rd(8'h1e);
    chk("cal_if", d, 8'h24);
    for (k = 0; k < 5; k++) chk("nvm_word", hdc_nvm_model_i.mem_q[k], vals[k]);
    wr(8'h1e, 8'h21); cyc(60);
    chk("nvm_count", hdc_nvm_model_i.n_q, 5);
    $display("test nvm done");
  endtask
  // Full-scale reference in each loop mode, with rated code 0xff and clamp code 0x55.
  task t_fullscale;
    closed_loop_i <= 1; resonant_i <= 0; cyc(4);
    chk("fs_code", full_scale_code_o, 8'hff);
    chk("fs_mv", full_scale_mv_o, 9'd272);
    chk("cal_code", cal_rated_code_o, 8'hff);
    resonant_i <= 1; cyc(4);
    chk("fs_mv", full_scale_mv_o, 9'd264);
    closed_loop_i <= 0; cyc(4);
    chk("fs_code", full_scale_code_o, 8'h55);
    $display("test fullscale done");
  endtask
  // Mid-run reset of a part whose memory is already programmed.
  task t_strap;
    nvm_blank_i <= 0; rst_i <= 1; cyc(2); rst_i <= 0; cyc(4);
    rd(8'h1e); chk("strap", d, 8'h24);
    wr(8'h1e, 8'h01); cyc(30); chk("nvm_count", hdc_nvm_model_i.n_q, 5);
    $display("test strap done");
  endtask
  task stop_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ====================
  // Main sequence, and a watchdog far beyond the expected run of under a thousand cycles.
  initial begin
    cyc(6); rst_i <= 0;
    t_reset; t_options; t_commutate; t_caltime; t_readback; t_nvm; t_fullscale; t_strap;
    stop_test;
  end
  initial begin
    #1000000 failures++;
    stop_test;
  end
endmodule
